/* include/rtf_map.svh */
`ifndef RTF_MAP_SVH
`define RTF_MAP_SVH

// ==========================================
// Request flag bit positions
`define RTF_FLG_SUBCAR   0
`define RTF_FLG_RATE     1
`define RTF_FLG_ENUM     2
`define RTF_FLG_EXT      3
`define RTF_FLG_B5       4
`define RTF_FLG_B6       5
`define RTF_FLG_OPT      6

// ==========================================
// Frame layout, byte positions after SOF
`define RTF_POS_CMD      4'h1
`define RTF_POS_UID0     4'h2
`define RTF_POS_UIDN     4'h9
`define RTF_POS_MAX      4'hF

// ==========================================
// Answer codes and reset values
`define RTF_ERR_OPTION   8'h03
`define RTF_BYTE_RST     8'h00

// ==========================================
// Timing
`define RTF_CLK_MHZ        10
`define RTF_FIELD_LOSS_US  1000

`endif

/* include/rtf_pkg.sv */
package rtf_pkg;

    // ==========================================
    // Tag states, one-hot
    typedef enum logic [3:0] {
        TAG_OFF   = 4'h1,
        TAG_READY = 4'h2,
        TAG_QUIET = 4'h4,
        TAG_SEL   = 4'h8
    } rtf_tag_state_type;

    // ==========================================
    // Request parser states, one-hot
    typedef enum logic [2:0] {
        PS_IDLE  = 3'h1,
        PS_FLAGS = 3'h2,
        PS_BODY  = 3'h4
    } rtf_parse_type;

endpackage

/* include/rtf_uid_if.sv */
`timescale 1ns/1ps

interface rtf_uid_if;
    logic       clear;
    logic       strobe;
    logic [2:0] index;
    logic [7:0] data;
    logic       match;

    modport requester (output clear, output strobe, output index, output data, input match);
    modport comparer  (input clear, input strobe, input index, input data, output match);
endinterface

/* hdl/rtf_field_sync.sv */
`timescale 1ns/1ps

module rtf_field_sync (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // Pin and result
    input  wire logic pin_in,
    output logic      level_out
);

    logic s1_reg, s2_reg, s3_reg, level_reg;
    logic level_next;

    // ==========================================
    // Level changes only once stages two and three agree
    always_comb begin
        level_next = level_reg;
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s1_reg    <= 1'b0;
            s2_reg    <= 1'b0;
            s3_reg    <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            s1_reg    <= pin_in;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_out = level_reg;

endmodule

/* hdl/rtf_uid_match.sv */
`timescale 1ns/1ps

module rtf_uid_match (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Own identity
    input  wire logic [63:0] own_id,
    // Byte stream
    rtf_uid_if.comparer      uid
);

    logic match_reg, match_next;

    // ==========================================
    // Byte-wise compare, LSByte first
    always_comb begin
        match_next = match_reg;
        if (uid.clear) begin
            match_next = 1'b1;
        end else if (uid.strobe) begin
            match_next = match_reg & (uid.data == own_id[{uid.index, 3'h0} +: 8]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            match_reg <= 1'b0;
        end else begin
            match_reg <= match_next;
        end
    end

    assign uid.match = match_reg;

endmodule

/* hdl/rtf_flag_gate.sv */
`timescale 1ns/1ps
`include "rtf_map.svh"

// Functional notes
// - Ready tag answers requests with select bit clear, ignores select-bit requests unless the address bit is also set.
// - Quiet tag answers all except select requests and enumeration requests with bit 6 set.
// - Selected tag answers select, matching addressed and non-addressed requests.
// - Select and address bits both set yields error reply code 03h.
// - Address bit set: compare 64-bit identity, act only on match.
// - Address bit clear: no identity field, every eligible tag executes.
// - Select bit set: only a selected tag executes; others stay silent unless the address bit is also set.
// - Field absent for the field loss interval forces power-off state.
// - Eight flag bits; bit 3 picks meaning of bits 5 to 8.
// - Flag bit 1 chooses one or two reply subcarriers.
// - Flag bit 2 chooses low or high reply data rate.
// - Flag bit 4 selects extended or standard protocol format.
// - Reader sets extension for block commands; system info reply follows it.
// - Non-enumeration bit 5 is select: clear follows address bit.
// - Non-enumeration bit 6 is address: identity field follows when set.
// - Enumeration bit 5 marks an application family byte present.
// - Enumeration bit 6: zero means sixteen slots, one means single slot.
// - Bad checksum discards the frame with no reply at all.
module rtf_flag_gate #(
    parameter int unsigned FIELD_LOSS_INTERVAL_US = `RTF_FIELD_LOSS_US
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // RF field presence pin
    input  wire logic        rf_field_present,
    // Received frame from the decoder
    input  wire logic        rx_sof,
    input  wire logic        rx_byte_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_eof,
    input  wire logic        rx_crc_ok,
    // Own identity
    input  wire logic [63:0] tag_serial_identity,
    // State moves from the command executor
    input  wire logic        cmd_to_ready,
    input  wire logic        cmd_to_quiet,
    input  wire logic        cmd_to_selected,
    // Decision
    output logic             req_execute,
    output logic             req_error,
    output logic [7:0]       req_error_code,
    output logic [7:0]       req_cmd_code,
    output logic             req_uid_matched,
    // Reply and request options
    output logic             reply_two_subcarriers,
    output logic             reply_high_rate,
    output logic             ext_format,
    output logic             inventory_req,
    output logic             family_filter_bit,
    output logic             slot_count_bit,
    output logic             option_bit,
    // Tag state
    output logic [3:0]       tag_state
);

    // ==========================================
    // Constants
    localparam int unsigned LOSS_CYC  = FIELD_LOSS_INTERVAL_US * `RTF_CLK_MHZ;
    localparam logic [19:0] LOSS_LAST = 20'(LOSS_CYC - 1);

    // ==========================================
    // Field presence and field loss timer
    logic        field_ok;
    logic [19:0] loss_cnt_reg, loss_cnt_next;
    logic        field_lost;

    rtf_field_sync u_sync (
        .core_clk  (core_clk),
        .srst      (srst),
        .pin_in    (rf_field_present),
        .level_out (field_ok)
    );

    assign field_lost = !field_ok && (loss_cnt_reg == LOSS_LAST);

    always_comb begin
        loss_cnt_next = loss_cnt_reg;
        if (field_ok) begin
            loss_cnt_next = 20'h00000;
        end else if (!field_lost) begin
            loss_cnt_next = loss_cnt_reg + 20'h00001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            loss_cnt_reg <= 20'h00000;
        end else begin
            loss_cnt_reg <= loss_cnt_next;
        end
    end

    // ==========================================
    // Request parser
    rtf_pkg::rtf_tag_state_type state_reg, state_next;
    rtf_pkg::rtf_parse_type     ps_reg, ps_next;
    logic [7:0] flags_reg, flags_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [3:0] cnt_reg, cnt_next;
    logic       f_enum, f_sel, f_addr, f_both;

    rtf_uid_if uid_if ();

    rtf_uid_match u_match (
        .core_clk (core_clk),
        .srst     (srst),
        .own_id   (tag_serial_identity),
        .uid      (uid_if)
    );

    // Bit 8 never looked at
    assign f_enum = flags_reg[`RTF_FLG_ENUM];
    assign f_sel  = !f_enum && flags_reg[`RTF_FLG_B5];
    assign f_addr = !f_enum && flags_reg[`RTF_FLG_B6];
    assign f_both = f_sel && f_addr;

    always_comb begin
        ps_next    = ps_reg;
        flags_next = flags_reg;
        cmd_next   = cmd_reg;
        cnt_next   = cnt_reg;
        if (state_reg == rtf_pkg::TAG_OFF) begin
            ps_next = rtf_pkg::PS_IDLE;
        end else if (rx_sof) begin
            ps_next  = rtf_pkg::PS_FLAGS;
            cnt_next = 4'h0;
        end else begin
            case (ps_reg)
                rtf_pkg::PS_IDLE: begin
                    ps_next = rtf_pkg::PS_IDLE;
                end
                rtf_pkg::PS_FLAGS: begin
                    if (rx_eof) begin
                        ps_next = rtf_pkg::PS_IDLE;
                    end else if (rx_byte_valid) begin
                        flags_next = rx_byte;
                        cnt_next   = `RTF_POS_CMD;
                        ps_next    = rtf_pkg::PS_BODY;
                    end
                end
                rtf_pkg::PS_BODY: begin
                    if (rx_eof) begin
                        ps_next = rtf_pkg::PS_IDLE;
                    end else if (rx_byte_valid) begin
                        if (cnt_reg == `RTF_POS_CMD) begin
                            cmd_next = rx_byte;
                        end
                        if (cnt_reg != `RTF_POS_MAX) begin
                            cnt_next = cnt_reg + 4'h1;
                        end
                    end
                end
                default: begin
                    ps_next = rtf_pkg::PS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ps_reg    <= rtf_pkg::PS_IDLE;
            flags_reg <= `RTF_BYTE_RST;
            cmd_reg   <= `RTF_BYTE_RST;
            cnt_reg   <= 4'h0;
        end else begin
            ps_reg    <= ps_next;
            flags_reg <= flags_next;
            cmd_reg   <= cmd_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Identity bytes follow the command only in addressed mode
    assign uid_if.clear  = rx_sof;
    assign uid_if.strobe = (ps_reg == rtf_pkg::PS_BODY) && rx_byte_valid && !rx_eof && f_addr
                           && (cnt_reg >= `RTF_POS_UID0) && (cnt_reg <= `RTF_POS_UIDN);
    assign uid_if.index  = 3'(cnt_reg - `RTF_POS_UID0);
    assign uid_if.data   = rx_byte;

    // ==========================================
    // Eligibility at end of frame
    logic frame_end, uid_full, uid_ok, state_ok, eligible, err_hit;

    assign frame_end = rx_eof && (ps_reg == rtf_pkg::PS_BODY) && (cnt_reg > `RTF_POS_CMD);
    assign uid_full  = cnt_reg > `RTF_POS_UIDN;
    assign uid_ok    = !f_addr || (uid_if.match && uid_full);

    always_comb begin
        state_ok = 1'b0;
        case (state_reg)
            rtf_pkg::TAG_READY: state_ok = !f_sel;
            rtf_pkg::TAG_QUIET: state_ok = !f_sel
                                           && !(f_enum && flags_reg[`RTF_FLG_B6]);
            rtf_pkg::TAG_SEL:   state_ok = 1'b1;
            default:            state_ok = 1'b0;
        endcase
    end

    // Checksum failure drops both answer and error
    assign eligible = frame_end && rx_crc_ok && state_ok && uid_ok && !f_both;
    assign err_hit  = frame_end && rx_crc_ok && f_both;

    // ==========================================
    // Decision outputs
    logic       exec_reg, exec_next;
    logic       err_reg, err_next;
    logic [7:0] code_reg, code_next;
    logic [7:0] ocmd_reg, ocmd_next;
    logic       umatch_reg, umatch_next;
    logic [6:0] opt_reg, opt_next;

    always_comb begin
        exec_next   = eligible;
        err_next    = err_hit;
        code_next   = code_reg;
        ocmd_next   = ocmd_reg;
        umatch_next = umatch_reg;
        opt_next    = opt_reg;
        if (err_hit) begin
            code_next = `RTF_ERR_OPTION;
        end
        if (eligible || err_hit) begin
            ocmd_next   = cmd_reg;
            umatch_next = f_addr && uid_ok;
            opt_next    = {flags_reg[`RTF_FLG_OPT],
                           f_enum && flags_reg[`RTF_FLG_B6],
                           f_enum && flags_reg[`RTF_FLG_B5],
                           f_enum,
                           flags_reg[`RTF_FLG_EXT],
                           flags_reg[`RTF_FLG_RATE],
                           flags_reg[`RTF_FLG_SUBCAR]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            exec_reg   <= 1'b0;
            err_reg    <= 1'b0;
            code_reg   <= `RTF_BYTE_RST;
            ocmd_reg   <= `RTF_BYTE_RST;
            umatch_reg <= 1'b0;
            opt_reg    <= 7'h00;
        end else begin
            exec_reg   <= exec_next;
            err_reg    <= err_next;
            code_reg   <= code_next;
            ocmd_reg   <= ocmd_next;
            umatch_reg <= umatch_next;
            opt_reg    <= opt_next;
        end
    end

    // ==========================================
    // Tag state; executor moves count only after a granted request
    logic grant_reg, grant_next;

    always_comb begin
        grant_next = grant_reg;
        if (field_lost || rx_sof) begin
            grant_next = 1'b0;
        end else if (eligible) begin
            grant_next = 1'b1;
        end
    end

    always_comb begin
        state_next = state_reg;
        if (field_lost) begin
            state_next = rtf_pkg::TAG_OFF;
        end else begin
            case (state_reg)
                rtf_pkg::TAG_OFF: begin
                    if (field_ok) begin
                        state_next = rtf_pkg::TAG_READY;
                    end
                end
                rtf_pkg::TAG_READY, rtf_pkg::TAG_QUIET, rtf_pkg::TAG_SEL: begin
                    if (grant_reg) begin
                        if (cmd_to_selected) begin
                            state_next = rtf_pkg::TAG_SEL;
                        end else if (cmd_to_quiet) begin
                            state_next = rtf_pkg::TAG_QUIET;
                        end else if (cmd_to_ready) begin
                            state_next = rtf_pkg::TAG_READY;
                        end
                    end
                end
                default: begin
                    state_next = rtf_pkg::TAG_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= rtf_pkg::TAG_OFF;
            grant_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            grant_reg <= grant_next;
        end
    end

    // ==========================================
    // Outputs
    assign req_execute           = exec_reg;
    assign req_error             = err_reg;
    assign req_error_code        = code_reg;
    assign req_cmd_code          = ocmd_reg;
    assign req_uid_matched       = umatch_reg;
    assign reply_two_subcarriers = opt_reg[0];
    assign reply_high_rate       = opt_reg[1];
    assign ext_format            = opt_reg[2];
    assign inventory_req         = opt_reg[3];
    assign family_filter_bit     = opt_reg[4];
    assign slot_count_bit        = opt_reg[5];
    assign option_bit            = opt_reg[6];
    assign tag_state             = state_reg;

    // ==========================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    chk_sel_silent: assert property (
        (frame_end && f_sel && state_reg != rtf_pkg::TAG_SEL) |=> !exec_reg)
        else $error("select request answered outside selected state");

    chk_quiet_inv: assert property (
        (frame_end && f_enum && flags_reg[5] && state_reg == rtf_pkg::TAG_QUIET) |=> !exec_reg)
        else $error("quiet tag answered enumeration request");

    chk_crc_drop: assert property (
        (rx_eof && !rx_crc_ok) |=> (!exec_reg && !err_reg))
        else $error("frame with bad checksum was answered");

    chk_both_error: assert property (
        (frame_end && rx_crc_ok && f_both) |=> (err_reg && !exec_reg && code_reg == 8'h03))
        else $error("select plus address did not give error 03h");

    chk_uid_miss: assert property (
        (frame_end && f_addr && !uid_if.match) |=> !exec_reg)
        else $error("addressed request answered without identity match");

    chk_nonaddr_exec: assert property (
        (frame_end && rx_crc_ok && !f_sel && !f_addr && !f_enum
         && state_reg != rtf_pkg::TAG_OFF) |=> exec_reg)
        else $error("general request not executed");

    chk_reply_opts: assert property (
        exec_reg |-> (reply_two_subcarriers == flags_reg[0] && reply_high_rate == flags_reg[1]))
        else $error("reply options differ from request flags");

    chk_loss_off: assert property (
        field_lost |=> (state_reg == rtf_pkg::TAG_OFF) ##1 (state_reg[3:2] == 2'h0))
        else $error("field loss did not force power-off");

    chk_no_change: assert property (
        (!grant_reg && !field_lost && state_reg != rtf_pkg::TAG_OFF) |=> $stable(state_reg))
        else $error("state moved without a granted request");

endmodule

/* verif/rtf_reader_model.sv */
`timescale 1ns/1ps

module rtf_reader_model (
    // Clock
    input  wire logic  core_clk,
    // Request frame toward the tag
    output logic       rx_sof,
    output logic       rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic       rx_eof,
    output logic       rx_crc_ok
);
    int   gap  = 0;
    logic busy = 1'b0;

    initial begin
        rx_sof        = 1'b0;
        rx_byte_valid = 1'b0;
        rx_byte       = 8'hA5;
        rx_eof        = 1'b0;
        rx_crc_ok     = 1'b0;
    end

    // Idle data line toggles so a stale byte never looks valid
    always @(posedge core_clk) begin
        if (!busy) begin
            rx_byte <= ~rx_byte;
        end
    end

    task automatic put(input logic [7:0] b);
        @(posedge core_clk);
        rx_sof        <= 1'b0;
        rx_byte_valid <= 1'b1;
        rx_byte       <= b;
        repeat (gap) begin
            @(posedge core_clk);
            rx_byte_valid <= 1'b0;
            rx_byte       <= ~rx_byte;
        end
    endtask

    // Flags, command, then identity low byte first
    task automatic send(input logic [7:0] f, input logic [7:0] c, input int nid,
                        input logic [63:0] id, input logic crc, input logic short_f);
        busy = 1'b1;
        @(posedge core_clk);
        rx_sof <= 1'b1;
        put(f);
        if (!short_f) put(c);
        for (int k = 0; k < nid; k++) put(id[8*k +: 8]);
        @(posedge core_clk);
        rx_byte_valid <= 1'b0;
        rx_byte       <= ~rx_byte;
        rx_eof        <= 1'b1;
        rx_crc_ok     <= crc;
        @(posedge core_clk);
        rx_eof    <= 1'b0;
        rx_crc_ok <= ~crc;
        busy = 1'b0;
    endtask
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps

module tb;
    // ============
    // Signals
    localparam int          LIMIT  = 40000;
    localparam logic [63:0] OWN_ID = 64'h5A3C_96F1_0B7D_C248; // Arbitrary identity
    typedef struct packed {
        logic [1:0] kind;
        logic [7:0] cmd;
        logic [7:0] flags;
    } rtf_note_type;
    logic         core_clk         = 1'b0;
    logic         srst             = 1'b1;
    logic         rf_field_present = 1'b1;
    logic [2:0]   cmd_go           = 3'h0;
    logic         rx_sof, rx_byte_valid, rx_eof, rx_crc_ok;
    logic [7:0]   rx_byte, req_error_code, req_cmd_code, got_opts;
    logic         req_execute, req_error, req_uid_matched;
    logic         reply_two_subcarriers, reply_high_rate, ext_format, inventory_req;
    logic         family_filter_bit, slot_count_bit, option_bit;
    logic [3:0]   tag_state;
    rtf_note_type q[$];
    rtf_note_type n;
    int           checks   = 0;
    int           failures = 0;
    int           cycles   = 0;

    rtf_flag_gate #(.FIELD_LOSS_INTERVAL_US(2)) u_rtf_flag_gate (
        .core_clk, .srst, .rf_field_present, .rx_sof, .rx_byte_valid, .rx_byte, .rx_eof,
        .rx_crc_ok, .tag_serial_identity(OWN_ID), .cmd_to_ready(cmd_go[0]),
        .cmd_to_quiet(cmd_go[1]), .cmd_to_selected(cmd_go[2]), .req_execute, .req_error,
        .req_error_code, .req_cmd_code, .req_uid_matched, .reply_two_subcarriers,
        .reply_high_rate, .ext_format, .inventory_req, .family_filter_bit,
        .slot_count_bit, .option_bit, .tag_state
    );
    rtf_reader_model u_rtf_reader_model (
        .core_clk, .rx_sof, .rx_byte_valid, .rx_byte, .rx_eof, .rx_crc_ok
    );

    assign got_opts = {1'b0, option_bit, slot_count_bit, family_filter_bit, ext_format,
                       inventory_req, reply_high_rate, reply_two_subcarriers};

    always #50 core_clk = ~core_clk;

    // ============
    // Checking
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] opts_of(input logic [7:0] f);
        return {1'b0, f[6], f[2] & f[5], f[2] & f[4], f[3], f[2], f[1], f[0]};
    endfunction

    function automatic logic [1:0] exp_kind(input logic [3:0] cur, input logic [7:0] f,
                                            input logic hit);
        logic sel;
        logic adr;
        sel = ~f[2] & f[4];
        adr = ~f[2] & f[5];
        if (cur == rtf_pkg::TAG_OFF) return 2'h0;
        if (sel && adr) return 2'h2;
        if (sel && cur != rtf_pkg::TAG_SEL) return 2'h0;
        if (cur == rtf_pkg::TAG_QUIET && f[2] && f[5]) return 2'h0;
        if (adr && !hit) return 2'h0;
        return 2'h1;
    endfunction

    // Oldest note meets each answer
    always @(negedge core_clk) begin
        if (req_execute === 1'b1 || req_error === 1'b1) begin
            if (q.size() == 0) begin
                failures++;
                $display("mismatch at %0t: answer without request", $time);
            end else begin
                n = q.pop_front();
                cmp({6'h00, req_error, req_execute}, {6'h00, n.kind}, "kind");
                cmp(req_cmd_code, n.cmd, "command");
                cmp(got_opts, opts_of(n.flags), "options");
                if (n.kind == 2'h2) cmp(req_error_code, 8'h03, "error code");
                else cmp({7'h00, req_uid_matched},
                         {7'h00, ~n.flags[2] & n.flags[5]}, "matched");
            end
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            $display("mismatch at %0t: timeout", $time);
            results();
        end
    end

    // ============
    // Stimulus
    task automatic frame(input logic [7:0] f, input logic [7:0] c, input logic [63:0] id,
                         input logic hit, input logic crc, input logic short_f);
        logic [1:0] k;
        logic [3:0] start_state;
        int         nid;
        start_state = tag_state;
        nid = (!f[2] && f[5]) ? 8 : ((f[2] && f[4]) ? 1 : 0);
        k   = (crc && !short_f) ? exp_kind(start_state, f, hit) : 2'h0;
        if (k != 2'h0) q.push_back({k, c, f});
        u_rtf_reader_model.send(f, c, nid, id, crc, short_f);
        repeat (2) @(negedge core_clk);
        cmp({4'h0, tag_state}, {4'h0, start_state}, "state kept");
    endtask

    task automatic go(input logic [2:0] bits);
        @(posedge core_clk);
        cmd_go <= bits;
        @(posedge core_clk);
        cmd_go <= 3'h0;
        repeat (2) @(negedge core_clk);
    endtask

    task automatic wait_state(input logic [3:0] want, input int limit, input string what);
        for (int k = 0; k < limit && tag_state !== want; k++) @(negedge core_clk);
        cmp({4'h0, tag_state}, {4'h0, want}, what);
    endtask

    // Every flag byte, random command and identity slips
    task automatic sweep(input int g, input string name);
        logic        hit;
        logic [63:0] id;
        u_rtf_reader_model.gap = g;
        for (int i = 0; i < 256; i++) begin
            hit = 1'($urandom % 2);
            id  = hit ? OWN_ID : OWN_ID ^ (64'h1 << ($urandom % 64));
            frame(8'(i), 8'($urandom), id, hit, 1'b1, 1'b0);
        end
        $display("test %s done", name);
    endtask

    initial begin
        void'($urandom(84203));
        repeat (19) @(posedge core_clk);
        @(negedge core_clk);
        cmp({4'h0, tag_state}, {4'h0, rtf_pkg::TAG_OFF}, "off in reset");
        @(posedge core_clk);
        srst <= 1'b0;
        wait_state(rtf_pkg::TAG_READY, 20, "ready");
        sweep(0, "ready sweep");
        frame(8'h10, 8'h20, OWN_ID, 1'b1, 1'b1, 1'b0);
        go(3'h4);
        wait_state(rtf_pkg::TAG_READY, 1, "no move");
        frame(8'h00, 8'h25, OWN_ID, 1'b1, 1'b1, 1'b0);
        go(3'h2);
        wait_state(rtf_pkg::TAG_QUIET, 2, "to quiet");
        sweep(1, "quiet sweep");
        frame(8'h00, 8'h26, OWN_ID, 1'b1, 1'b1, 1'b0);
        go(3'h6);
        wait_state(rtf_pkg::TAG_SEL, 2, "to selected");
        sweep(2, "selected sweep");
        frame(8'h02, 8'h21, OWN_ID, 1'b1, 1'b0, 1'b0);
        frame(8'h02, 8'h21, OWN_ID, 1'b1, 1'b1, 1'b1);
        $display("test checksum and length done");
        @(posedge core_clk);
        rf_field_present <= 1'b0;
        repeat (15) @(negedge core_clk);
        cmp({4'h0, tag_state}, {4'h0, rtf_pkg::TAG_SEL}, "early off");
        wait_state(rtf_pkg::TAG_OFF, 20, "field loss");
        frame(8'h00, 8'h22, OWN_ID, 1'b1, 1'b1, 1'b0);
        @(posedge core_clk);
        rf_field_present <= 1'b1;
        wait_state(rtf_pkg::TAG_READY, 10, "field back");
        $display("test field loss done");
        repeat (4) @(posedge core_clk);
        cmp(8'(q.size()), 8'h00, "answers missing");
        results();
    end
endmodule
